// [pkg/ces_pkg.sv]
package ces_pkg;

  // Register map, one aligned 32-bit word each
  localparam int unsigned ADDR_W      = 8;
  localparam logic [7:0]  OFS_CTRL     = 8'h00;
  localparam logic [7:0]  OFS_COUNT_LO = 8'h04;
  localparam logic [7:0]  OFS_COUNT_HI = 8'h08;
  localparam logic [7:0]  OFS_STATUS   = 8'h0C;

  // Control word fields and reset values
  localparam int unsigned CTRL_CODE_LSB = 0;
  localparam int unsigned CTRL_MASK_LSB = 8;
  localparam int unsigned CTRL_EN_BIT   = 16;
  localparam int unsigned CTRL_CLR_BIT  = 17;
  localparam logic [7:0]  CODE_RST      = 8'h00;
  localparam logic [7:0]  MASK_RST      = 8'h00;

  // Event codes
  localparam logic [7:0] EV_REMOTE_RESPONSE_RETRY_SET0 = 8'h26;
  localparam logic [7:0] EV_REMOTE_RESPONSE_RETRY_SET1 = 8'h27;
  localparam logic [7:0] EV_WRITEBACK_RETRY_SET0       = 8'h28;
  localparam logic [7:0] EV_WRITEBACK_RETRY_SET1       = 8'h29;
  localparam logic [7:0] EV_FILTER_CAPACITY_EVICTION   = 8'h3D;
  localparam logic [7:0] EV_SNOOPS_ISSUED              = 8'h51;
  localparam logic [7:0] EV_SNOOP_REPLY_COUNT          = 8'h5C;

  // Bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    reply_invalid, reply_shared, reply_invalid_forward, reply_shared_forward,
    reply_invalid_writeback, reply_shared_writeback, reply_forward_writeback,
    reply_conflict, reply_conflict_writeback, reply_forward_only
  } ces_reply_t;

  // Raw retry conditions; set1 bit n lines up with unit-mask bit n+1
  typedef struct packed {
    logic [7:0] remote_response_set0;
    logic [6:0] remote_response_set1;
    logic [7:0] writeback_set0;
    logic [6:0] writeback_set1;
  } ces_retry_t;

  typedef struct packed {
    logic valid;
    logic clean;
    logic modified;
    logic exclusive;
    logic shared;
  } ces_evict_t;

  typedef struct packed {
    logic valid;
    logic remote;
    logic directed;
  } ces_issue_t;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } ces_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } ces_axi_rsp_t;

endpackage

// [rtl/ces_axil_slave.sv]
module ces_axil_slave
  import ces_pkg::*;
(
  input  wire logic              i_clock,
  input  wire logic              i_rst,
  input  wire ces_axi_req_t      i_axi,
  output ces_axi_rsp_t           o_axi,
  output logic                   o_wr_en,
  output logic [ADDR_W-1:0]      o_wr_addr,
  output logic [31:0]            o_wr_data,
  output logic [3:0]             o_wr_strb,
  input  wire logic              i_wr_err,
  output logic                   o_rd_en,
  output logic [ADDR_W-1:0]      o_rd_addr,
  input  wire logic [31:0]       i_rd_data,
  input  wire logic              i_rd_err
);

  logic              aw_held_q, w_held_q, bvalid_q, rvalid_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0]       wdata_q, rdata_q;
  logic [3:0]        wstrb_q;
  logic [1:0]        bresp_q, rresp_q;

  ////////////////////////////////////////////////////////////////////////////
  // Address and data are caught independently, so either may come first
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
    end
    else
    begin
      if (o_axi.awready && i_axi.awvalid)
      begin
        aw_held_q <= 1'b1;
        awaddr_q  <= i_axi.awaddr;
      end
      else if (o_wr_en)
        aw_held_q <= 1'b0;
      if (o_axi.wready && i_axi.wvalid)
      begin
        w_held_q <= 1'b1;
        wdata_q  <= i_axi.wdata;
        wstrb_q  <= i_axi.wstrb;
      end
      else if (o_wr_en)
        w_held_q <= 1'b0;
    end
  end

  // Write answer is raised on the same edge as the register update
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end
    else if (o_wr_en)
    begin
      bvalid_q <= 1'b1;
      bresp_q  <= i_wr_err ? RESP_SLVERR : RESP_OKAY;
    end
    else if (i_axi.bready)
      bvalid_q <= 1'b0;
  end

  // Reads have no side effects, so data is sampled at the address handshake
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= RESP_OKAY;
    end
    else if (o_rd_en)
    begin
      rvalid_q <= 1'b1;
      rdata_q  <= i_rd_data;
      rresp_q  <= i_rd_err ? RESP_SLVERR : RESP_OKAY;
    end
    else if (i_axi.rready)
      rvalid_q <= 1'b0;
  end

  // Handshake outputs
  always_comb
  begin
    o_axi.awready = !aw_held_q && !bvalid_q;
    o_axi.wready  = !w_held_q && !bvalid_q;
    o_axi.bvalid  = bvalid_q;
    o_axi.bresp   = bresp_q;
    o_axi.arready = !rvalid_q;
    o_axi.rvalid  = rvalid_q;
    o_axi.rdata   = rdata_q;
    o_axi.rresp   = rresp_q;
  end

  assign o_wr_en   = aw_held_q && w_held_q && !bvalid_q;
  assign o_wr_addr = awaddr_q;
  assign o_wr_data = wdata_q;
  assign o_wr_strb = wstrb_q;
  assign o_rd_en   = i_axi.arvalid && !rvalid_q;
  assign o_rd_addr = i_axi.araddr;

endmodule

// [rtl/ces_event_match.sv]
module ces_event_match
  import ces_pkg::*;
#(
  parameter int unsigned LANES = 3,
  parameter int unsigned INC_W = 2
)
(
  input  wire logic [7:0]       i_code,
  input  wire logic [7:0]       i_umask,
  input  wire ces_retry_t       i_retry,
  input  wire ces_evict_t       i_evict,
  input  wire ces_issue_t       i_issue,
  input  wire logic [LANES-1:0] i_reply_valid,
  input  wire ces_reply_t       i_reply_kind [LANES],
  output logic [INC_W-1:0]      o_incr,
  output logic                  o_known
);

  // The increment must hold every lane counting at once
  if (LANES < 1 || INC_W < $clog2(LANES + 1))
  begin : g_bad_param
    $error("ces_event_match: LANES must be 1 or more and INC_W wide enough for it");
  end

  // Set1 retry: bit 0 is the OR of all set0 conditions, the rest map 1:1
  function automatic logic set1_hit(input logic [7:0] set0, input logic [6:0] set1,
                                    input logic [7:0] umask);
    set1_hit = (umask[0] && |set0) || |(umask[7:1] & set1); // see RULE_02 see RULE_10
  endfunction

  // Reply kinds folded onto their unit-mask bit
  function automatic logic reply_hit(input ces_reply_t kind, input logic [7:0] umask);
    unique case (kind)
      reply_invalid:            reply_hit = umask[0]; // see RULE_16
      reply_shared:             reply_hit = umask[1];
      reply_invalid_forward:    reply_hit = umask[2];
      reply_shared_forward:     reply_hit = umask[3];
      reply_invalid_writeback,
      reply_shared_writeback:   reply_hit = umask[4]; // see RULE_17
      reply_forward_writeback:  reply_hit = umask[5]; // see RULE_18
      reply_conflict,
      reply_conflict_writeback: reply_hit = umask[6]; // see RULE_19
      reply_forward_only:       reply_hit = umask[7]; // see RULE_20
      default:                  reply_hit = 1'b0;
    endcase
  endfunction

  logic [LANES-1:0] lane_hit;

  ////////////////////////////////////////////////////////////////////////////
  // Every reply lane is judged on its own so each one counts
  for (genvar g = 0; g < LANES; g++)
  begin : g_lane
    assign lane_hit[g] = i_reply_valid[g] && reply_hit(i_reply_kind[g], i_umask);
  end

  // Event selection; unknown codes never count
  always_comb
  begin
    o_incr  = '0;
    o_known = 1'b1;
    unique case (i_code)
      EV_REMOTE_RESPONSE_RETRY_SET0:
        o_incr = INC_W'(|(i_umask & i_retry.remote_response_set0)); // see RULE_21
      EV_REMOTE_RESPONSE_RETRY_SET1: // see RULE_04
        o_incr = INC_W'(set1_hit(i_retry.remote_response_set0, // see RULE_01 see RULE_03
                                 i_retry.remote_response_set1, i_umask)); // see RULE_05
      EV_WRITEBACK_RETRY_SET0: // see RULE_08 see RULE_09
        o_incr = INC_W'(|(i_umask & i_retry.writeback_set0)); // see RULE_06 see RULE_07
      EV_WRITEBACK_RETRY_SET1:
        o_incr = INC_W'(set1_hit(i_retry.writeback_set0, i_retry.writeback_set1, i_umask));
      EV_FILTER_CAPACITY_EVICTION: // Bits 7:3 undefined, see RULE_23
        o_incr = INC_W'(i_evict.valid && !i_evict.clean && // see RULE_12
                 |(i_umask[2:0] & {i_evict.shared, i_evict.exclusive,
                                   i_evict.modified})); // see RULE_11
      EV_SNOOPS_ISSUED: // Bit 1 undefined, see RULE_23
        o_incr = INC_W'(i_issue.valid && (i_umask[0] // see RULE_13
                 || (i_umask[2] && !i_issue.remote) || (i_umask[3] && i_issue.remote)
                 || (i_umask[4] && !i_issue.remote && !i_issue.directed) // see RULE_14
                 || (i_umask[5] && i_issue.remote && !i_issue.directed)
                 || (i_umask[6] && !i_issue.remote && i_issue.directed)
                 || (i_umask[7] && i_issue.remote && i_issue.directed)));
      EV_SNOOP_REPLY_COUNT:
        for (int i = 0; i < LANES; i++)
          o_incr = o_incr + INC_W'(lane_hit[i]); // see RULE_15
      default:
        o_known = 1'b0;
    endcase
  end

endmodule

// [rtl/ces_event_select.sv]
// Function
// (RULE_01) Code 0x27 counts retries of the remote response queue, second set.
// (RULE_02) In that set, mask bit 0 counts any condition of its first set.
// (RULE_03) Second sets: bits 1-4 home agent, cache victim, filter victim, victim.
// (RULE_04) Second sets: bit 5 counts way conflicts in cache or snoop filter.
// (RULE_05) Second sets: bit 6 snoop allowed, bit 7 physical address conflict.
// (RULE_06) Code 0x28 counts retries of the writeback queue, first set.
// (RULE_07) Its bits 0-3: missing credits for command request/response, payload reply/writeback.
// (RULE_08) Its bits 4 and 5: missing payload credits for noncoherent bypass/standard.
// (RULE_09) Its bits 6 and 7: cannot inject acknowledge or invalidate ring message.
// (RULE_10) Code 0x29 is writeback second set; bit 0 counts any first-set condition.
// (RULE_11) Code 0x3D counts capacity evictions; bits 0-2 select modified, exclusive, shared.
// (RULE_12) Clean evictions are never counted.
// (RULE_13) Code 0x51 counts issued snoops; bit 0 all, bits 2-3 local, remote.
// (RULE_14) Bits 4-5 broadcast local/remote, bits 6-7 directed local/remote snoops.
// (RULE_15) Code 0x5C counts snoop replies; every matching reply adds one.
// (RULE_16) Reply bits 0-3: invalid, shared, invalid-forward, shared-forward.
// (RULE_17) Reply bit 4 matches invalid-writeback or shared-writeback.
// (RULE_18) Reply bit 5 selects forward-with-writeback replies.
// (RULE_19) Reply bit 6 selects both conflict reply kinds.
// (RULE_20) Reply bit 7 selects forward-only replies.
// (RULE_21) Code 0x26 first sets use the same eight credit conditions order.
// (RULE_22) Any selected condition adds one per cycle; set bits are ORed.
// (RULE_23) Mask bits undefined for the selected event never count.
//
// Local design decisions: the register offsets and the AXI4-Lite slave port.
module ces_event_select
  import ces_pkg::*;
#(
  parameter int unsigned CNT_W = 48,
  parameter int unsigned LANES = 3
)
(
  input  wire logic             i_clock,
  input  wire logic             i_rst,
  input  wire ces_axi_req_t     i_axi,
  output ces_axi_rsp_t          o_axi,
  input  wire ces_retry_t       i_retry,
  input  wire ces_evict_t       i_evict,
  input  wire ces_issue_t       i_issue,
  input  wire logic [LANES-1:0] i_reply_valid,
  input  wire ces_reply_t       i_reply_kind [LANES]
);

  localparam int unsigned INC_W = $clog2(LANES + 1);

  // The high count word carries CNT_W-32 bits and must not be empty
  if (CNT_W < 33 || CNT_W > 63 || LANES < 1 || LANES > 15)
  begin : g_bad_param
    $error("ces_event_select: CNT_W must be 33..63 and LANES 1..15");
  end

  logic              wr_en, rd_en, rd_err, wr_err, known, clr;
  logic [ADDR_W-1:0] wr_addr, rd_addr;
  logic [31:0]       wr_data, rd_data;
  logic [3:0]        wr_strb;
  logic [INC_W-1:0]  incr;
  logic [7:0]        code_q, mask_q;
  logic              en_q, hit_q;
  logic [CNT_W-1:0]  count_q;

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave and event qualification
  ces_axil_slave u_bus (
    .i_clock   (i_clock),
    .i_rst     (i_rst),
    .i_axi     (i_axi),
    .o_axi     (o_axi),
    .o_wr_en   (wr_en),
    .o_wr_addr (wr_addr),
    .o_wr_data (wr_data),
    .o_wr_strb (wr_strb),
    .i_wr_err  (wr_err),
    .o_rd_en   (rd_en),
    .o_rd_addr (rd_addr),
    .i_rd_data (rd_data),
    .i_rd_err  (rd_err)
  );

  ces_event_match #(
    .LANES (LANES),
    .INC_W (INC_W)
  ) u_match (
    .i_code        (code_q),
    .i_umask       (mask_q),
    .i_retry       (i_retry),
    .i_evict       (i_evict),
    .i_issue       (i_issue),
    .i_reply_valid (i_reply_valid),
    .i_reply_kind  (i_reply_kind),
    .o_incr        (incr),
    .o_known       (known)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Control word, byte-lane writes
  assign wr_err = !(wr_addr == OFS_CTRL || wr_addr == OFS_COUNT_LO ||
                    wr_addr == OFS_COUNT_HI || wr_addr == OFS_STATUS);
  assign clr    = wr_en && wr_addr == OFS_CTRL && wr_strb[2] && wr_data[CTRL_CLR_BIT];

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      code_q <= CODE_RST;
      mask_q <= MASK_RST;
      en_q   <= 1'b0;
    end
    else if (wr_en && wr_addr == OFS_CTRL)
    begin
      if (wr_strb[0])
        code_q <= wr_data[CTRL_CODE_LSB +: 8];
      if (wr_strb[1])
        mask_q <= wr_data[CTRL_MASK_LSB +: 8];
      if (wr_strb[2])
        en_q <= wr_data[CTRL_EN_BIT];
    end
  end

  // Counter; an event in the clearing cycle survives as the new start value
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
      count_q <= '0;
    else if (clr)
      count_q <= en_q ? CNT_W'(incr) : '0;
    else if (en_q)
      count_q <= count_q + CNT_W'(incr); // see RULE_22
  end

  // Last-cycle hit, visible in status for bring-up
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
      hit_q <= 1'b0;
    else
      hit_q <= en_q && incr != '0;
  end

  // Read decode; unmapped words answer with an error
  always_comb
  begin
    rd_data = '0;
    rd_err  = 1'b0;
    unique case (rd_addr)
      OFS_CTRL:     rd_data = {15'h0, en_q, mask_q, code_q};
      OFS_COUNT_LO: rd_data = count_q[31:0];
      OFS_COUNT_HI: rd_data = {{(64 - CNT_W){1'b0}}, count_q[CNT_W-1:32]};
      OFS_STATUS:   rd_data = {29'h0, hit_q, known, en_q};
      default:      rd_err  = 1'b1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the qualification and counting
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst);

  chk_count_step: assert property ( // see RULE_22
    en_q && !clr |=> count_q == $past(count_q) + CNT_W'($past(incr)))
    else $error("counter did not advance by the qualified amount");

  chk_count_hold: assert property (
    !en_q && !clr |=> count_q == $past(count_q))
    else $error("counter moved while disabled");

  chk_clear_keeps: assert property ( // see RULE_22
    clr && en_q ##1 !clr && en_q |=> count_q == CNT_W'($past(incr, 2)) + CNT_W'($past(incr)))
    else $error("event in clearing cycle lost");

  chk_resp_set0: assert property ( // see RULE_21
    code_q == EV_REMOTE_RESPONSE_RETRY_SET0 |->
      incr == INC_W'(|(mask_q & i_retry.remote_response_set0)))
    else $error("remote response set0 qualification wrong");

  chk_resp_any_set0_condition: assert property ( // see RULE_02
    code_q == EV_REMOTE_RESPONSE_RETRY_SET1 && mask_q[0] &&
      |i_retry.remote_response_set0 && en_q && !clr |=> count_q == $past(count_q) + 1'b1)
    else $error("remote response any-set0 bit did not count once");

  chk_resp_set1: assert property ( // see RULE_01 see RULE_03 see RULE_04 see RULE_05
    code_q == EV_REMOTE_RESPONSE_RETRY_SET1 |->
      incr == INC_W'(mask_q[0] && |i_retry.remote_response_set0 ||
                     |(mask_q[7:1] & i_retry.remote_response_set1)))
    else $error("remote response set1 qualification wrong");

  chk_wb_set0: assert property ( // see RULE_06 see RULE_07 see RULE_08 see RULE_09
    code_q == EV_WRITEBACK_RETRY_SET0 |->
      incr == INC_W'(|(mask_q & i_retry.writeback_set0)))
    else $error("writeback set0 qualification wrong");

  chk_wb_set1: assert property ( // see RULE_10
    code_q == EV_WRITEBACK_RETRY_SET1 && mask_q == 8'h01 |->
      incr == INC_W'(|i_retry.writeback_set0))
    else $error("writeback set1 any-set0 bit wrong");

  chk_evict_state: assert property ( // see RULE_11
    code_q == EV_FILTER_CAPACITY_EVICTION && i_evict.valid && !i_evict.clean &&
      |(mask_q[2:0] & {i_evict.shared, i_evict.exclusive, i_evict.modified}) |->
      incr == INC_W'(1))
    else $error("dirty eviction of selected state not counted");

  chk_evict_clean: assert property ( // see RULE_12
    code_q == EV_FILTER_CAPACITY_EVICTION && i_evict.clean |-> incr == '0)
    else $error("clean eviction counted");

  chk_undef_bits: assert property ( // see RULE_23
    (code_q == EV_FILTER_CAPACITY_EVICTION && mask_q[2:0] == 3'h0) ||
      (code_q == EV_SNOOPS_ISSUED && mask_q == 8'h02) || !known |-> incr == '0)
    else $error("undefined mask bit or code counted");

  chk_issue_all: assert property ( // see RULE_13 see RULE_14
    code_q == EV_SNOOPS_ISSUED |->
      incr == INC_W'(i_issue.valid && (mask_q[0] ||
        mask_q[{2'b01, i_issue.remote}] ||
        mask_q[{1'b1, i_issue.directed, i_issue.remote}])))
    else $error("snoop issue qualification wrong");

  chk_reply_all: assert property ( // see RULE_15 see RULE_17 see RULE_19
    code_q == EV_SNOOP_REPLY_COUNT && mask_q == 8'hFF |->
      incr == INC_W'($countones(i_reply_valid)))
    else $error("not every reply counted");

  chk_reply_none: assert property ( // see RULE_16 see RULE_18 see RULE_20
    code_q == EV_SNOOP_REPLY_COUNT && mask_q == 8'h00 |-> incr == '0)
    else $error("reply counted with empty mask");

endmodule

// [tb/ces_far_model.sv]
module ces_far_model
  import ces_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_go,
  input  wire logic [1:0]  i_kind,
  input  wire logic [31:0] i_arg,
  output ces_retry_t       o_retry,
  output ces_evict_t       o_evict,
  output ces_issue_t       o_issue,
  output logic [2:0]       o_reply_valid,
  output ces_reply_t       o_reply_kind [3]
);
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////
  // One kind of activity per command, for a single cycle; idle lines other than the reply kinds fall to zero
  // so a stale level can never be counted a second time
  always_ff @(posedge i_clock)
  begin
    o_retry       <= (i_go && i_kind == 2'h0) ? ces_retry_t'(i_arg[29:0]) : '0;
    o_evict       <= (i_go && i_kind == 2'h1) ? ces_evict_t'(i_arg[4:0]) : '0;
    o_issue       <= (i_go && i_kind == 2'h2) ? ces_issue_t'(i_arg[2:0]) : '0;
    o_reply_valid <= (i_go && i_kind == 2'h3) ? i_arg[14:12] : 3'h0;
    // Kinds keep moving even on idle lanes, so a lane that ignores valid shows
    for (int k = 0; k < 3; k++)
      o_reply_kind[k] <= ces_reply_t'(i_arg[4*k +: 4]);
  end
endmodule

// [tb/test_ces_event_select.sv]
module test_ces_event_select
  import ces_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  logic         i_clock      = 1'b0;
  logic         i_rst        = 1'b1;
  ces_axi_req_t axi          = '0;
  ces_axi_rsp_t rsp;
  logic         go           = 1'b0;
  logic [1:0]   kind         = 2'h0;
  logic [31:0]  arg          = 32'h0;
  ces_retry_t   retry;
  ces_evict_t   evict;
  ces_issue_t   issue;
  logic [2:0]   rvld;
  ces_reply_t   rkind [3];
  logic [31:0]  rd_data;
  logic [1:0]   rd_resp;
  logic [1:0]   wr_resp;
  int           error_cnt    = 0;
  int           total_checks = 0;

  ces_event_select ces_event_select_i (
    .i_clock       (i_clock),
    .i_rst         (i_rst),
    .i_axi         (axi),
    .o_axi         (rsp),
    .i_retry       (retry),
    .i_evict       (evict),
    .i_issue       (issue),
    .i_reply_valid (rvld),
    .i_reply_kind  (rkind)
  );

  ces_far_model ces_far_model_i (
    .i_clock       (i_clock),
    .i_go          (go),
    .i_kind        (kind),
    .i_arg         (arg),
    .o_retry       (retry),
    .o_evict       (evict),
    .o_issue       (issue),
    .o_reply_valid (rvld),
    .o_reply_kind  (rkind)
  );

  ////////////////////////////////////////////////////////////
  // 20 MHz clock
  always #25 i_clock = ~i_clock;

  task automatic stop_test();
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Address and data offered together; bready stays high for the whole run
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    axi.awvalid <= 1'b1;
    axi.awaddr  <= a;
    axi.wvalid  <= 1'b1;
    axi.wdata   <= d;
    axi.wstrb   <= 4'hF;
    do
    begin
      @(posedge i_clock);
      n++;
      if (rsp.awready)
        axi.awvalid <= 1'b0;
      if (rsp.wready)
        axi.wvalid <= 1'b0;
    end while (!rsp.bvalid && n < 40);
    if (!rsp.bvalid)
    begin
      error_cnt++;
      stop_test();
    end
    else
      wr_resp = rsp.bresp;
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    axi.arvalid <= 1'b1;
    axi.araddr  <= a;
    do
    begin
      @(posedge i_clock);
      n++;
      if (rsp.arready)
        axi.arvalid <= 1'b0;
    end while (!rsp.rvalid && n < 40);
    if (!rsp.rvalid)
    begin
      error_cnt++;
      stop_test();
    end
    else
    begin
      rd_data = rsp.rdata;
      rd_resp = rsp.rresp;
    end
  endtask

  // One cycle of far-side activity, then let it reach the counter
  task automatic pulse(input logic [1:0] k, input logic [31:0] v);
    go   <= 1'b1;
    kind <= k;
    arg  <= v;
    @(posedge i_clock);
    go <= 1'b0;
    repeat (2) @(posedge i_clock);
  endtask

  // Clear and arm, one event, disarm, a second event that must be lost
  task automatic run(input logic [7:0] c, input logic [7:0] m, input logic [1:0] k,
                     input logic [31:0] v, input logic [31:0] e);
    wr(OFS_CTRL, {14'h0, 2'h3, m, c});
    pulse(k, v);
    wr(OFS_CTRL, 32'h0);
    pulse(k, v);
    rd(OFS_COUNT_LO);
    chk(rd_data, e);
    $display("test code=%h mask=%h done", c, m);
  endtask

  ////////////////////////////////////////////////////////////
  // Hang guard well above the length of the sequence
  initial
  begin
    repeat (20000) @(posedge i_clock);
    error_cnt++;
    stop_test();
  end

  initial
  begin
    axi.bready <= 1'b1;
    axi.rready <= 1'b1;
    repeat (6) @(posedge i_clock);
    i_rst <= 1'b0;
    @(posedge i_clock);
    rd(OFS_CTRL);
    chk(rd_data, 32'h0);
    rd(8'h10);
    chk({30'h0, rd_resp}, {30'h0, RESP_SLVERR});
    chk(rd_data, 32'h0);
    wr(8'h14, 32'hFFFFFFFF);
    chk({30'h0, wr_resp}, {30'h0, RESP_SLVERR});
    wr(OFS_CTRL, 32'h0001FF28);
    rd(OFS_CTRL);
    chk(rd_data, 32'h0001FF28);
    rd(OFS_STATUS);
    chk(rd_data, 32'h3);
    wr(OFS_CTRL, 32'h00010030);
    rd(OFS_STATUS);
    chk(rd_data, 32'h1);
    rd(OFS_COUNT_HI);
    chk(rd_data, 32'h0);
    $display("test registers done");
    // Retry sets
    run(8'h28, 8'h01, 2'h0, 32'h80, 32'h1);
    run(8'h28, 8'h80, 2'h0, 32'h2000, 32'h0);
    run(8'h28, 8'hC0, 2'h0, 32'h4000, 32'h1);
    run(8'h28, 8'h3C, 2'h0, 32'h1800, 32'h1);
    run(8'h28, 8'hFF, 2'h0, 32'h7F80, 32'h1);
    run(8'h29, 8'h01, 2'h0, 32'h400, 32'h1);
    run(8'h29, 8'h02, 2'h0, 32'h1, 32'h1);
    run(8'h29, 8'h20, 2'h0, 32'h10, 32'h1);
    run(8'h27, 8'h80, 2'h0, 32'h200000, 32'h1);
    run(8'h27, 8'h7F, 2'h0, 32'h200000, 32'h0);
    run(8'h27, 8'h40, 2'h0, 32'h100000, 32'h1);
    run(8'h27, 8'h01, 2'h0, 32'h1000000, 32'h1);
    run(8'h26, 8'h20, 2'h0, 32'h8000000, 32'h1);
    run(8'h26, 8'h01, 2'h0, 32'h80, 32'h0);
    run(8'h30, 8'hFF, 2'h0, 32'h3FFFFFFF, 32'h0);
    // Capacity evictions
    run(8'h3D, 8'h01, 2'h1, 32'h14, 32'h1);
    run(8'h3D, 8'h02, 2'h1, 32'h12, 32'h1);
    run(8'h3D, 8'h04, 2'h1, 32'h11, 32'h1);
    run(8'h3D, 8'h01, 2'h1, 32'h12, 32'h0);
    run(8'h3D, 8'h07, 2'h1, 32'h1C, 32'h0);
    run(8'h3D, 8'hF8, 2'h1, 32'h11, 32'h0);
    // Issued snoops
    run(8'h51, 8'h01, 2'h2, 32'h4, 32'h1);
    run(8'h51, 8'h04, 2'h2, 32'h4, 32'h1);
    run(8'h51, 8'h04, 2'h2, 32'h6, 32'h0);
    run(8'h51, 8'h08, 2'h2, 32'h6, 32'h1);
    run(8'h51, 8'h10, 2'h2, 32'h4, 32'h1);
    run(8'h51, 8'h20, 2'h2, 32'h6, 32'h1);
    run(8'h51, 8'h40, 2'h2, 32'h5, 32'h1);
    run(8'h51, 8'h10, 2'h2, 32'h5, 32'h0);
    run(8'h51, 8'h80, 2'h2, 32'h7, 32'h1);
    run(8'h51, 8'h02, 2'h2, 32'h4, 32'h0);
    // Snoop replies, several lanes in one cycle
    run(8'h5C, 8'h01, 2'h3, 32'h7000, 32'h3);
    run(8'h5C, 8'h01, 2'h3, 32'h5000, 32'h2);
    run(8'h5C, 8'h02, 2'h3, 32'h7111, 32'h3);
    run(8'h5C, 8'h2C, 2'h3, 32'h7623, 32'h3);
    run(8'h5C, 8'h10, 2'h3, 32'h7154, 32'h2);
    run(8'h5C, 8'h20, 2'h3, 32'h3069, 32'h1);
    run(8'h5C, 8'h40, 2'h3, 32'h7987, 32'h2);
    run(8'h5C, 8'h80, 2'h3, 32'h3069, 32'h1);
    run(8'h5C, 8'hFF, 2'h3, 32'h7540, 32'h3);
    stop_test();
  end
endmodule
